// *** inc/llt_pkg.sv ***
// constants for the level limit timer: register map, fields, modes
// assumes a 32-bit apb bus with word-aligned registers
package llt_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL = 8'h00; // run, prescale, postscale
    localparam logic [7:0] OFS_MODE = 8'h04; // limit mode field
    localparam logic [7:0] OFS_PERIOD = 8'h08; // period_value
    localparam logic [7:0] OFS_COMPARE = 8'h0C; // pulse_width_compare
    localparam logic [7:0] OFS_COUNT = 8'h10; // live count, read only
    localparam logic [7:0] OFS_STATUS = 8'h14; // live status, read only
    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int RUN_BIT = 7; // timer run bit
    localparam int PS_HI = 6; // prescale_select top bit
    localparam int PS_LO = 4; // prescale_select low bit
    localparam int POST_HI = 3; // postscale_select top bit
    localparam int POST_LO = 0; // postscale_select low bit
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [4:0] RST_MODE = 5'h00;
    localparam logic [7:0] RST_PERIOD = 8'hFF;
    localparam logic [7:0] RST_COMPARE = 8'h00;
    // ------------------------------------------------------------
    // mode encodings
    // ------------------------------------------------------------
    localparam logic [4:0] MODE_FREE_LOW = 5'b00110; // reset on low level
    localparam logic [4:0] MODE_FREE_HIGH = 5'b00111; // reset on high level
    localparam logic [4:0] MODE_ONE_LOW = 5'b10110; // one-shot, low level
    localparam logic [4:0] MODE_ONE_HIGH = 5'b10111; // one-shot, high level
    // ------------------------------------------------------------
    // timing: reset level is seen after this many timer clocks
    // ------------------------------------------------------------
    localparam int ERS_DELAY = 2;
endpackage : llt_pkg

// *** rtl/level_limit_timer.sv ***
// level limit timer: 8-bit period timer with level hardware limit modes
// assumes apb master on pclk and an external reset level synchronous to pclk
//
// Operation
// - free low mode: hold counter while input low
// - free high mode: hold counter while input high
// - run bit clear: external input ignored
// - pwm rises on start, falls on compare
// - clear on period match or two-clock reset
// - resume after match or two clocks post-release
// - reset during high pwm keeps it high
// - one-shot modes hold counter at reset level
// - one-shot starts when run and input inactive
// - one-shot period match clears count and run
// - after run cleared, stay reset until restart
// - one-shot pwm rises on whichever event starts
`timescale 1ns/1ns
module level_limit_timer (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link to outside
    input wire logic external_reset_input,
    output logic pwm_out,
    output logic period_event
);
    import llt_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic run_q; // timer run bit
    logic [2:0] prescale_select_q; // clock divider code
    logic [3:0] postscale_select_q; // period events per output pulse, less one
    logic [4:0] mode_q; // limit mode
    logic [7:0] period_value_q; // period_value
    logic [7:0] pulse_width_compare_q; // pulse_width_compare
    logic [7:0] count_q; // timer count
    logic [6:0] pre_q; // prescaler counter
    logic [3:0] post_q; // postscaler counter
    logic [ERS_DELAY-1:0] ers_q; // reset level seen on timer clocks
    logic idle_q; // counter not yet started
    logic pwm_q; // pwm drive
    logic event_q; // postscaled period pulse
    logic [31:0] prdata_q; // read data

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic wr_en; // write takes effect this edge
    logic setup_rd; // read setup cycle
    logic mapped; // address hits a register
    logic [6:0] pre_mask; // prescale terminal mask
    logic tick; // one timer clock
    logic level_mode; // a level limit mode is selected
    logic one_shot; // one-shot variant
    logic ers_active; // input at selected reset level
    logic hold; // counter held by external level
    logic stall; // held, or idle and waiting for the level to go inactive
    logic match; // count equals period_value
    logic sw_run_set; // software writes the run bit to one

    assign wr_en = psel & penable & pwrite;
    assign setup_rd = psel & ~penable & ~pwrite;
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~mapped;

    // address match, unmapped answers with pslverr
    always_comb begin
        if (paddr == OFS_CONTROL) begin
            mapped = 1'b1;
        end else if (paddr == OFS_MODE) begin
            mapped = 1'b1;
        end else if (paddr == OFS_PERIOD) begin
            mapped = 1'b1;
        end else if (paddr == OFS_COMPARE) begin
            mapped = 1'b1;
        end else if (paddr == OFS_COUNT) begin
            mapped = 1'b1;
        end else if (paddr == OFS_STATUS) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // mode decode: the four level encodings are matched in full, bit 0 the level
    assign level_mode = (mode_q == MODE_FREE_LOW) | (mode_q == MODE_FREE_HIGH)
                      | (mode_q == MODE_ONE_LOW) | (mode_q == MODE_ONE_HIGH);
    assign one_shot = level_mode & mode_q[4];
    // mode bit 0 picks whether the low or the high level counts as reset
    assign ers_active = level_mode & (mode_q[0] ? external_reset_input
                                                : ~external_reset_input);
    // held once the level has stood for two timer clocks
    assign hold = &ers_q;
    // an idle counter never starts while the input sits at the reset level
    assign stall = hold | (idle_q & ers_active);
    assign match = (count_q == period_value_q);
    assign sw_run_set = wr_en & (paddr == OFS_CONTROL) & pwdata[RUN_BIT];

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    assign pre_mask = 7'((8'h01 << prescale_select_q) - 8'h01);
    assign tick = run_q & ((pre_q & pre_mask) == pre_mask);

    // free running divider, cleared while stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= '0;
        end else if (!run_q) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 7'h01;
        end
    end

    // ------------------------------------------------------------
    // control register: run bit is set by software, cleared by hardware
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= RST_CONTROL[RUN_BIT];
            prescale_select_q <= RST_CONTROL[PS_HI:PS_LO];
            postscale_select_q <= RST_CONTROL[POST_HI:POST_LO];
        end else begin
            if (wr_en && paddr == OFS_CONTROL) begin
                run_q <= pwdata[RUN_BIT];
                prescale_select_q <= pwdata[PS_HI:PS_LO];
                postscale_select_q <= pwdata[POST_HI:POST_LO];
            end else if (tick && one_shot && !hold && match && !idle_q) begin
                run_q <= 1'b0;
            end
        end
    end

    // remaining writable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= RST_MODE;
            period_value_q <= RST_PERIOD;
            pulse_width_compare_q <= RST_COMPARE;
        end else if (wr_en) begin
            if (paddr == OFS_MODE) begin
                mode_q <= pwdata[4:0];
            end else if (paddr == OFS_PERIOD) begin
                period_value_q <= pwdata[7:0];
            end else if (paddr == OFS_COMPARE) begin
                pulse_width_compare_q <= pwdata[7:0];
            end
        end
    end

    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (setup_rd) begin
            if (paddr == OFS_CONTROL) begin
                prdata_q <= {24'h00_0000, run_q, prescale_select_q, postscale_select_q};
            end else if (paddr == OFS_MODE) begin
                prdata_q <= {27'h000_0000, mode_q};
            end else if (paddr == OFS_PERIOD) begin
                prdata_q <= {24'h00_0000, period_value_q};
            end else if (paddr == OFS_COMPARE) begin
                prdata_q <= {24'h00_0000, pulse_width_compare_q};
            end else if (paddr == OFS_COUNT) begin
                prdata_q <= {24'h00_0000, count_q};
            end else if (paddr == OFS_STATUS) begin
                prdata_q <= {28'h000_0000, hold, idle_q, pwm_q, run_q};
            end else begin
                prdata_q <= '0;
            end
        end
    end
    assign prdata = prdata_q;

    // ------------------------------------------------------------
    // external reset level pipeline, on timer clocks
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ers_q <= '0;
        end else if (!run_q) begin
            ers_q <= '0;
        end else if (tick) begin
            ers_q <= {ers_q[ERS_DELAY-2:0], ers_active};
        end
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
        end else if (!run_q) begin
            count_q <= '0;
        end else if (tick) begin
            if (stall) begin
                count_q <= '0;
            end else if (match) begin
                count_q <= '0;
            end else begin
                count_q <= count_q + 8'h01;
            end
        end
    end

    // start flag: set while stopped or held, cleared on the first count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_q <= 1'b1;
        end else if (!run_q) begin
            idle_q <= 1'b1;
        end else if (tick) begin
            idle_q <= stall;
        end
    end

    // ------------------------------------------------------------
    // pwm drive
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_q <= 1'b0;
        end else if (!run_q) begin
            pwm_q <= 1'b0;
        end else if (tick && !stall) begin
            // a one-shot match ends the run, so the pulse is not restarted there
            if (idle_q || (match && !one_shot)) begin
                pwm_q <= 1'b1;
            end else if (count_q == pulse_width_compare_q) begin
                pwm_q <= 1'b0;
            end
        end
    end
    assign pwm_out = pwm_q;

    // ------------------------------------------------------------
    // postscaler on period matches
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            post_q <= '0;
            event_q <= 1'b0;
        end else if (!run_q) begin
            post_q <= '0;
            event_q <= 1'b0;
        end else begin
            event_q <= 1'b0;
            if (tick && !hold && match && !idle_q) begin
                if (post_q == postscale_select_q) begin
                    post_q <= '0;
                    event_q <= 1'b1;
                end else begin
                    post_q <= post_q + 4'h1;
                end
            end
        end
    end
    assign period_event = event_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_RUN_OFF_CLEAR: assert property (!run_q |=> count_q == 8'h00 && !pwm_q)
        else $error("count or pwm not reset while stopped");
    AST_IGNORE_ERS: assert property (!run_q |=> ers_q == '0 && !hold)
        else $error("external level seen while stopped");
    AST_HOLD_CLEAR: assert property (run_q && tick && hold |=> count_q == 8'h00)
        else $error("count not cleared while held");
    AST_LEVEL_TO_HOLD: assert property (
            run_q && tick && ers_active && ers_q[0] |=> hold)
        else $error("reset level did not hold after two timer clocks");
    AST_MATCH_CLEAR: assert property (
            run_q && tick && !hold && match |=> count_q == 8'h00)
        else $error("period match did not clear count");
    AST_ONESHOT_OFF: assert property (
            tick && one_shot && !hold && match && !idle_q && !wr_en |=> !run_q)
        else $error("one-shot match did not clear run");
    AST_PWM_FALL: assert property (
            tick && !hold && !idle_q && !match
            && count_q == pulse_width_compare_q |=> !pwm_q)
        else $error("pwm not low at compare");
    AST_PWM_KEEP: assert property (run_q && pwm_q && hold |=> pwm_q)
        else $error("pwm dropped while held");
    AST_START_HIGH: assert property (
            run_q && tick && !stall && idle_q |=> pwm_q && !idle_q)
        else $error("pwm not raised at start");
    AST_RESTART: assert property (!run_q && !sw_run_set |=> !run_q && idle_q)
        else $error("timer left reset without run");
endmodule : level_limit_timer

// *** dv/ers_source.sv ***
// far-side model: drives the external reset level, tallies pwm and period pulses
// assumes one pclk domain and a bench that changes requests after rising edges
`timescale 1ns/1ns
module ers_source (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // requests from the bench
    input wire logic ers_req,
    input wire logic cnt_clr,
    // timer outputs watched
    input wire logic pwm_out,
    input wire logic period_event,
    // level to the timer and tallies
    output logic external_reset_input,
    output logic [31:0] hi_n,
    output logic [31:0] ev_n
);
    // level launched on a clock edge, as a synchronous source would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            external_reset_input <= 1'b1;
        end else begin
            external_reset_input <= ers_req;
        end
    end
    // tally of pwm high cycles and period pulses, cleared on request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_n <= 32'h0000_0000;
            ev_n <= 32'h0000_0000;
        end else if (cnt_clr) begin
            hi_n <= 32'h0000_0000;
            ev_n <= 32'h0000_0000;
        end else begin
            hi_n <= hi_n + {31'h0, pwm_out === 1'b1};
            ev_n <= ev_n + {31'h0, period_event === 1'b1};
        end
    end
endmodule : ers_source

// *** dv/tb_level_limit_timer.sv ***
// testbench for the level limit timer: apb tasks and directed scenarios
// assumes ers_source as far side and zero-wait apb answers
`timescale 1ns/1ns
module tb_level_limit_timer;
    import llt_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic ers_req = 1, cnt_clr = 0, pready, pslverr, ers, pwm_out, period_event, err;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdv, hi_n, ev_n;
    int mismatches = 0, checks_done = 0;
    always #4 pclk = ~pclk;
    level_limit_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_reset_input(ers), .pwm_out(pwm_out),
        .period_event(period_event));
    ers_source i_far (.pclk(pclk), .presetn(presetn), .ers_req(ers_req), .cnt_clr(cnt_clr),
        .pwm_out(pwm_out), .period_event(period_event), .external_reset_input(ers),
        .hi_n(hi_n), .ev_n(ev_n));
    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // value must lie between two bounds
    task automatic rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        checks_done++;
        if ($isunknown(got) || got < lo || got > hi) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : rng
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(0, a, 32'h0000_0000);
        cmp(rdv, exp);
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc
    task automatic conclude;
        $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    // watchdog against a hung handshake
    initial begin
        cyc(20000);
        mismatches++;
        conclude();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        cyc(12);
        presetn <= 1;
        rd(OFS_CONTROL, {24'h0, RST_CONTROL});
        rd(OFS_PERIOD, {24'h0, RST_PERIOD});
        rd(OFS_COMPARE, {24'h0, RST_COMPARE});
        rd(OFS_MODE, {27'h0, RST_MODE});
        apb(1, 8'h20, 32'h0000_1234);
        cmp({31'h0, err}, 32'h0000_0001);
        // stopped timer ignores an active low level: idle only
        apb(1, OFS_MODE, {27'h0, MODE_FREE_LOW});
        ers_req <= 0;
        cyc(6);
        rd(OFS_STATUS, 32'h0000_0004);
        apb(1, OFS_PERIOD, 32'h0000_0009);
        apb(1, OFS_COMPARE, 32'h0000_0004);
        apb(1, OFS_CONTROL, 32'h0000_0080);
        cyc(10);
        rd(OFS_COUNT, 32'h0000_0000);
        ers_req <= 1;
        cyc(20);
        cnt_clr <= 1;
        cyc(1);
        cnt_clr <= 0;
        cyc(100);
        rng(hi_n, 49, 51);
        rng(ev_n, 10, 10);
        // active level while pwm is high keeps it high
        do @(posedge pclk); while (pwm_out !== 1'b1);
        ers_req <= 0;
        cyc(12);
        cmp({31'h0, pwm_out}, 32'h0000_0001);
        rd(OFS_COUNT, 32'h0000_0000);
        ers_req <= 1;
        apb(1, OFS_MODE, {27'h0, MODE_FREE_HIGH});
        cyc(10);
        rd(OFS_COUNT, 32'h0000_0000);
        // prescale: divide by 8, then by 128
        apb(1, OFS_MODE, 32'h0000_0000);
        apb(1, OFS_PERIOD, 32'h0000_00FF);
        apb(1, OFS_CONTROL, 32'h0000_0000);
        apb(1, OFS_CONTROL, 32'h0000_00B0);
        cyc(160);
        apb(0, OFS_COUNT, 32'h0000_0000);
        rng(rdv, 18, 22);
        apb(1, OFS_CONTROL, 32'h0000_0000);
        apb(1, OFS_CONTROL, 32'h0000_00F0);
        cyc(1300);
        apb(0, OFS_COUNT, 32'h0000_0000);
        rng(rdv, 9, 11);
        // one-shot on low level: start by release of the level
        apb(1, OFS_CONTROL, 32'h0000_0000);
        apb(1, OFS_MODE, {27'h0, MODE_ONE_LOW});
        apb(1, OFS_PERIOD, 32'h0000_0014);
        apb(1, OFS_COMPARE, 32'h0000_000F);
        ers_req <= 0;
        apb(1, OFS_CONTROL, 32'h0000_0080);
        cyc(10);
        rd(OFS_COUNT, 32'h0000_0000);
        cmp({31'h0, pwm_out}, 32'h0000_0000);
        rd(OFS_CONTROL, 32'h0000_0080);
        ers_req <= 1;
        cyc(6);
        cmp({31'h0, pwm_out}, 32'h0000_0001);
        cyc(40);
        rd(OFS_CONTROL, 32'h0000_0000);
        rd(OFS_COUNT, 32'h0000_0000);
        // restart by setting the run bit with the level already inactive
        apb(1, OFS_CONTROL, 32'h0000_0080);
        cyc(4);
        cmp({31'h0, pwm_out}, 32'h0000_0001);
        // one-shot on high level: run set while held, start by release
        apb(1, OFS_CONTROL, 32'h0000_0000);
        apb(1, OFS_MODE, {27'h0, MODE_ONE_HIGH});
        apb(1, OFS_CONTROL, 32'h0000_0080);
        cyc(10);
        rd(OFS_COUNT, 32'h0000_0000);
        cmp({31'h0, pwm_out}, 32'h0000_0000);
        ers_req <= 0;
        cyc(40);
        rd(OFS_CONTROL, 32'h0000_0000);
        // postscale 1:2 on a free period of ten timer clocks
        apb(1, OFS_MODE, 32'h0000_0000);
        apb(1, OFS_PERIOD, 32'h0000_0009);
        apb(1, OFS_CONTROL, 32'h0000_0081);
        cnt_clr <= 1;
        cyc(1);
        cnt_clr <= 0;
        cyc(100);
        rng(ev_n, 4, 4);
        conclude();
    end
endmodule : tb_level_limit_timer
